//--- core/pwm_array_pkg.sv
// Constants and types for the multi-channel PWM timer array
package pwm_array_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH     = 4;
    localparam int MASTER_CH  = 0;
    localparam int CNT_W      = 16;
    localparam int HALF_W     = 8;
    localparam int EXP_W      = 4;
    localparam int ADDR_W     = 8;

    typedef logic [CNT_W-1:0]  cnt_t;
    typedef logic [NUM_CH-1:0] chmask_t;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_RELOAD0   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT0    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LEVEL     = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_OUT_EN    = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_POLARITY  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_ROLE      = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_START     = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STOP      = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_ENABLE    = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_CONFIG    = 8'h3C;
    localparam logic [ADDR_W-1:0] OFS_LAST      = 8'h3C;
    localparam int                WORD_SHIFT    = 2;

    // Config register fields
    localparam int CFG_SPLIT_LSB  = 0;
    localparam int CFG_CKSEL_LSB  = 4;
    localparam int CFG_EXPA_LSB   = 8;
    localparam int CFG_EXPB_LSB   = 12;
    // Only these channels can be split into two 8-bit halves
    localparam chmask_t SPLIT_CAPABLE = 4'hA;

    // ------------------------------------------------------------------
    // Reset and special values
    // ------------------------------------------------------------------
    localparam cnt_t    RELOAD_RST = 16'hFFFF;
    localparam cnt_t    COUNT_RST  = 16'hFFFF;
    localparam cnt_t    STOP_VAL   = 16'hFFFF;
    localparam cnt_t    ZERO_VAL   = 16'h0000;
    localparam cnt_t    ONE_VAL    = 16'h0001;
    localparam chmask_t MASK_RST   = 4'h0;
    localparam logic [15:0] CFG_RST = 16'h0000;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic [31:0] RDATA_NONE   = 32'h0000_0000;

    // Output role: 0 = master output mode, 1 = slave output mode
    localparam logic ROLE_MASTER = 1'b0;

    typedef enum logic [1:0] {
        CH_STOPPED  = 2'b00,
        CH_ARMED    = 2'b01,
        CH_COUNTING = 2'b10,
        CH_WAITING  = 2'b11
    } chan_state_e;

endpackage

//--- core/pwm_array.sv
// Timer array with one interval master and up to three PWM slaves
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - Master reloads, counts down, period reload+1
// - Slave duty equals reload over master reload+1
// - Slave reload beyond period gives full duty
// - Slave loads duty on master event, counts down
// - Slave at zero interrupts, parks at FFFFH
// - Pin active next tick, inactive at zero
// - Channel zero master, three slave channels
// - Counters are sixteen bits wide
// - Split channel uses only its low half
// - Reload values reach counters on master event
// - Output enable off drives static level bit
// - Polarity bit selects active high or low
// - Role bit selects master or slave output
// - Level bit drives pin while counting output off
// - Polarity ignored in master output mode
// - Stop clears enable, holds counters and pins
// - Start and stop triggers read back zero
module pwm_array
    import pwm_array_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    output logic [NUM_CH-1:0]      pwm_pin,
    output logic [NUM_CH-1:0]      channel_interrupt
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] low_mask(
        input logic [EXP_W-1:0] e);
        low_mask = CNT_W'((32'h1 << e) - 32'h1);
    endfunction

    function automatic logic [CNT_W-1:0] eff_reload(
        input logic [CNT_W-1:0] v, input logic split);
        eff_reload = split ? {{HALF_W{1'b0}}, v[HALF_W-1:0]} : v;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]  reload_r [NUM_CH];
    logic [CNT_W-1:0]  count_r  [NUM_CH];
    chan_state_e       state_r  [NUM_CH];
    chmask_t           level_r;
    chmask_t           out_en_r;
    chmask_t           polarity_r;
    chmask_t           role_r;
    chmask_t           enable_r;
    logic [15:0]       config_r;
    logic [CNT_W-1:0]  presc_r;
    chmask_t           irq_r;

    logic [ADDR_W-1:0] addr_r;
    logic              wr_pend_r;
    logic              rd_pend_r;
    logic              rd_wait_r;
    logic [31:0]       hrdata_r;

    logic              tick_a;
    logic              tick_b;
    chmask_t           tick;
    chmask_t           fire;
    logic              master_event;
    chmask_t           start_req;
    chmask_t           stop_req;
    logic              wr_now;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic addr_phase;
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_now     = wr_pend_r;
    // Reads spend one wait state so a preceding write is seen
    assign hreadyout  = !(rd_pend_r && !rd_wait_r);
    assign hresp      = HRESP_OKAY;
    assign hrdata     = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r    <= '0;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else if (hreadyout) begin
            addr_r    <= haddr[ADDR_W-1:0];
            wr_pend_r <= addr_phase && hwrite;
            rd_pend_r <= addr_phase && !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_r <= 1'b0;
            hrdata_r  <= RDATA_NONE;
        end else begin
            rd_wait_r <= rd_pend_r && !rd_wait_r;
            if (rd_pend_r && !rd_wait_r) begin
                if (addr_r < OFS_COUNT0) begin
                    hrdata_r <= 32'(reload_r[addr_r[3:2]]);
                end else if (addr_r < OFS_LEVEL) begin
                    hrdata_r <= 32'(count_r[addr_r[3:2]]);
                end else if (addr_r == OFS_LEVEL) begin
                    hrdata_r <= 32'(level_r);
                end else if (addr_r == OFS_OUT_EN) begin
                    hrdata_r <= 32'(out_en_r);
                end else if (addr_r == OFS_POLARITY) begin
                    hrdata_r <= 32'(polarity_r);
                end else if (addr_r == OFS_ROLE) begin
                    hrdata_r <= 32'(role_r);
                end else if (addr_r == OFS_ENABLE) begin
                    hrdata_r <= 32'(enable_r);
                end else if (addr_r == OFS_CONFIG) begin
                    hrdata_r <= 32'(config_r);
                end else begin
                    hrdata_r <= RDATA_NONE;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign start_req = (wr_now && addr_r == OFS_START) ?
                       hwdata[NUM_CH-1:0] : MASK_RST;
    assign stop_req  = (wr_now && addr_r == OFS_STOP) ?
                       hwdata[NUM_CH-1:0] : MASK_RST;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                reload_r[i] <= RELOAD_RST;
            end
            out_en_r   <= MASK_RST;
            polarity_r <= MASK_RST;
            role_r     <= MASK_RST;
            config_r   <= CFG_RST;
        end else if (wr_now) begin
            // Reloads are only staged here; counters pick them up later
            if (addr_r < OFS_COUNT0) begin
                reload_r[addr_r[3:2]] <= hwdata[CNT_W-1:0];
            end else if (addr_r == OFS_OUT_EN) begin
                out_en_r <= hwdata[NUM_CH-1:0];
            end else if (addr_r == OFS_POLARITY) begin
                polarity_r <= hwdata[NUM_CH-1:0];
            end else if (addr_r == OFS_ROLE) begin
                role_r <= hwdata[NUM_CH-1:0];
            end else if (addr_r == OFS_CONFIG) begin
                config_r <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Operating clocks from a free prescaler
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= ZERO_VAL;
        end else begin
            presc_r <= presc_r + ONE_VAL;
        end
    end

    assign tick_a = (presc_r & low_mask(config_r[CFG_EXPA_LSB +: EXP_W]))
                    == low_mask(config_r[CFG_EXPA_LSB +: EXP_W]);
    assign tick_b = (presc_r & low_mask(config_r[CFG_EXPB_LSB +: EXP_W]))
                    == low_mask(config_r[CFG_EXPB_LSB +: EXP_W]);

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            tick[i] = config_r[CFG_CKSEL_LSB + i] ? tick_b : tick_a;
        end
    end

    // ------------------------------------------------------------------
    // Channel events
    // ------------------------------------------------------------------
    always_comb begin
        fire[MASTER_CH] = tick[MASTER_CH] && !start_req[MASTER_CH] &&
            !stop_req[MASTER_CH] && (state_r[MASTER_CH] == CH_ARMED ||
             (state_r[MASTER_CH] == CH_COUNTING &&
              count_r[MASTER_CH] == ZERO_VAL));
        for (int i = 1; i < NUM_CH; i++) begin
            fire[i] = tick[i] && state_r[i] == CH_COUNTING && !stop_req[i] &&
                      count_r[i] == ZERO_VAL && !start_req[i];
        end
    end
    assign master_event = fire[MASTER_CH];

    // ------------------------------------------------------------------
    // Enable status and counters
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= MASK_RST;
        end else begin
            enable_r <= (enable_r & ~stop_req) | start_req;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                count_r[i] <= COUNT_RST;
                state_r[i] <= CH_STOPPED;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (start_req[i]) begin
                    state_r[i] <= (i == MASTER_CH) ? CH_ARMED
                                                   : CH_WAITING;
                end else if (stop_req[i]) begin
                    state_r[i] <= CH_STOPPED;
                end else if (i == MASTER_CH) begin
                    if (fire[i]) begin
                        count_r[i] <= reload_r[i];
                        state_r[i] <= CH_COUNTING;
                    end else if (state_r[i] == CH_COUNTING && tick[i]) begin
                        count_r[i] <= count_r[i] - ONE_VAL;
                    end
                end else if (state_r[i] != CH_STOPPED && master_event) begin
                    count_r[i] <= eff_reload(reload_r[i],
                        config_r[CFG_SPLIT_LSB + i] &&
                        SPLIT_CAPABLE[i]);
                    state_r[i] <= CH_COUNTING;
                end else if (fire[i]) begin
                    count_r[i] <= STOP_VAL;
                    state_r[i] <= CH_WAITING;
                end else if (state_r[i] == CH_COUNTING && tick[i]) begin
                    count_r[i] <= count_r[i] - ONE_VAL;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= MASK_RST;
        end else begin
            irq_r <= fire;
        end
    end
    assign channel_interrupt = irq_r;

    // ------------------------------------------------------------------
    // Output latch: software level or count-driven
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_r <= MASK_RST;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!out_en_r[i]) begin
                    if (wr_now && addr_r == OFS_LEVEL) begin
                        level_r[i] <= hwdata[i];
                    end
                end else if (role_r[i] == ROLE_MASTER) begin
                    if (fire[i]) begin
                        level_r[i] <= !level_r[i];
                    end
                end else if (i != MASTER_CH &&
                             state_r[i] == CH_COUNTING && tick[i] &&
                             !stop_req[i]) begin
                    // Zero count goes inactive, else active
                    level_r[i] <= (count_r[i] != ZERO_VAL) ^
                                  polarity_r[i];
                end
            end
        end
    end
    assign pwm_pin = level_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_master_reload: assert property (
        fire[0] |=> count_r[0] == $past(reload_r[0]))
        else $error("master did not reload at its event");
    a_slave_load: assert property (
        master_event && state_r[1] == CH_WAITING && !start_req[1] &&
        !stop_req[1] && !config_r[CFG_SPLIT_LSB + 1]
        |=> count_r[1] == $past(reload_r[1]) && state_r[1] == CH_COUNTING)
        else $error("slave did not load duty on master event");
    a_slave_park: assert property (
        fire[2] && !start_req[2] && !stop_req[2] && !master_event
        |=> count_r[2] == STOP_VAL && state_r[2] == CH_WAITING
            && channel_interrupt[2])
        else $error("slave did not park after reaching zero");
    a_pin_active: assert property (
        state_r[1] == CH_COUNTING && tick[1] && !stop_req[1] &&
        out_en_r[1] && role_r[1] && count_r[1] != ZERO_VAL && !polarity_r[1]
        |=> pwm_pin[1])
        else $error("slave pin not active while counting");
    a_pin_inactive: assert property (
        fire[3] && out_en_r[3] && role_r[3]
        |=> pwm_pin[3] == polarity_r[3])
        else $error("slave pin not inactive at zero");
    a_split_low: assert property (
        master_event && state_r[3] == CH_WAITING && !start_req[3] &&
        !stop_req[3] && config_r[CFG_SPLIT_LSB + 3]
        |=> count_r[3][CNT_W-1:HALF_W] == '0)
        else $error("split slave used upper half");
    a_static_level: assert property (
        !out_en_r[2] && $stable(out_en_r[2]) && !(wr_now &&
        addr_r == OFS_LEVEL) |=> $stable(pwm_pin[2]))
        else $error("pin moved while output enable off");
    a_stop_holds: assert property (
        stop_req[0] && !start_req[0]
        |=> !enable_r[0] && state_r[0] == CH_STOPPED
            ##1 $stable(count_r[0]) [*2])
        else $error("stop did not hold the counter");
    a_start_enable: assert property (
        start_req[0] |=> enable_r[0] && state_r[0] == CH_ARMED)
        else $error("start did not enable master");
    a_okay_resp: assert property (hresp == HRESP_OKAY)
        else $error("slave response not okay");

    c_master_event: cover property (fire[0] ##[1:50] fire[0]);
    c_slave_zero:   cover property (master_event ##[1:50] fire[1]);
    c_full_duty:    cover property (master_event && state_r[2] ==
                                    CH_COUNTING && count_r[2] != ZERO_VAL);
    c_stop_run:     cover property (stop_req[0] && enable_r[0]);

endmodule // pwm_array

//--- test/tb_top.sv
// Self-checking testbench for the multi-channel PWM timer array
`timescale 1ns/1ps
module tb_top
    import pwm_array_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic [NUM_CH-1:0] pwm_pin;
    logic [NUM_CH-1:0] channel_interrupt;
    int                err_count;
    int                total_checks;
    int                cycles;
    int                per;
    int                act [4];
    int                irq [4];
    cnt_t              de;
    logic [31:0]       ex;
    logic [31:0]       x;
    chmask_t           pins;

    typedef struct packed {
        cnt_t             r0;
        logic [3:1][15:0] d;
        chmask_t          pol;
        chmask_t          split;
    } row_s;

    row_s row;
    // Period, duties of slaves 3..1, polarity, split
    row_s rows [4] = '{
        '{16'h0009, {16'h000A, 16'h0000, 16'h0003}, 4'h0, 4'h0},
        '{16'h000F, {16'h000F, 16'h0014, 16'h0108}, 4'hA, 4'hA},
        '{16'h00FE, {16'h0080, 16'h0001, 16'h00FF}, 4'h4, 4'h0},
        '{16'h0001, {16'h0000, 16'h0002, 16'h0001}, 4'h0, 4'h0}
    };

    assign hready = hreadyout;

    pwm_array pwm_array_inst (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hready),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .hrdata            (hrdata),
        .pwm_pin           (pwm_pin),
        .channel_interrupt (channel_interrupt)
    );

    always #12.5 hclk = ~hclk;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp_v,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp_v) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp_v, got);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Longest row needs about three periods of 255 cycles plus bus traffic
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------
    // Ready is sampled at the falling edge so it is settled at the next rise
    task automatic bus(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic rdy;
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr_en;
        haddr  <= {24'h000000, a};
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            rd  = hrdata;
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h00000000, v);
        check(n, e, v);
    endtask

    // ------------------------------------------------------------------
    // Waveform measurement over one master period
    // ------------------------------------------------------------------
    task automatic wait_event;
        do @(negedge hclk); while (channel_interrupt[0] !== 1'b1);
    endtask

    task automatic measure(input chmask_t pol);
        per = 0;
        act = '{default: 0};
        irq = '{default: 0};
        wait_event();
        do begin
            @(negedge hclk);
            per++;
            for (int s = 1; s < 4; s++) begin
                if ((pwm_pin[s] ^ pol[s]) === 1'b1) act[s]++;
                if (channel_interrupt[s] === 1'b1) irq[s]++;
            end
        end while (channel_interrupt[0] !== 1'b1 && per < 1000);
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0;
        htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        err_count = 0; total_checks = 0; cycles = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check("pins after reset", 32'h0, {28'h0, pwm_pin});
        @(posedge hclk);
        rd_chk("reload0", OFS_RELOAD0, 32'h0000FFFF);
        rd_chk("counter2", OFS_COUNT0 + 8'h08, 32'h0000FFFF);
        rd_chk("config", OFS_CONFIG, 32'h00000000);
        rd_chk("enable", OFS_ENABLE, 32'h00000000);

        foreach (rows[i]) begin
            row = rows[i];
            wr(OFS_STOP, 32'h0000000F);
            wr(OFS_RELOAD0, {16'h0000, row.r0});
            for (int s = 1; s < 4; s++)
                wr(OFS_RELOAD0 + 8'(4 * s), {16'h0000, row.d[s]});
            wr(OFS_POLARITY, {28'h0, row.pol});
            wr(OFS_CONFIG, {28'h0, row.split});
            wr(OFS_ROLE, 32'h0000000E);
            wr(OFS_OUT_EN, 32'h0000000E);
            wr(OFS_START, 32'h0000000F);
            rd_chk("enable", OFS_ENABLE, 32'h0000000F);
            rd_chk("start", OFS_START, 32'h00000000);
            rd_chk("reload0", OFS_RELOAD0, {16'h0000, row.r0});
            wait_event();
            measure(row.pol);
            check("period", 32'(row.r0) + 1, 32'(per));
            for (int s = 1; s < 4; s++) begin
                de = row.split[s] ? {8'h00, row.d[s][7:0]} : row.d[s];
                ex = (de > row.r0) ? 32'(row.r0) + 1 : 32'(de);
                check("duty", ex, 32'(act[s]));
                ex = (de <= row.r0) ? 32'h1 : 32'h0;
                check("slave irq", ex, 32'(irq[s]));
            end
        end

        // Clock b at half rate on all channels, last row's reloads
        wr(OFS_STOP, 32'h0000000F);
        wr(OFS_CONFIG, 32'h000010F0);
        wr(OFS_POLARITY, 32'h00000001);
        wr(OFS_OUT_EN, 32'h0000000F);
        wr(OFS_START, 32'h0000000F);
        wait_event();
        measure(4'h0);
        check("half period", 32'(2 * (row.r0 + 1)), 32'(per));
        check("half duty1", 32'h2, 32'(act[1]));
        check("half duty2", 32'h4, 32'(act[2]));
        check("half duty3", 32'h0, 32'(act[3]));
        check("half irq1", 32'h1, 32'(irq[1]));
        check("half irq2", 32'h0, 32'(irq[2]));
        check("half irq3", 32'h1, 32'(irq[3]));
        // Master output mode toggles on each period, polarity ignored
        @(negedge hclk);
        pins = pwm_pin;
        wait_event();
        check("master toggle", {31'h0, !pins[0]}, {31'h0, pwm_pin[0]});
        @(posedge hclk);

        // Stop holds counters and pins
        wr(OFS_STOP, 32'h0000000F);
        rd_chk("enable", OFS_ENABLE, 32'h00000000);
        rd_chk("stop", OFS_STOP, 32'h00000000);
        bus(1'b0, OFS_COUNT0 + 8'h04, 32'h0, x);
        @(negedge hclk);
        pins = pwm_pin;
        repeat (10) @(posedge hclk);
        rd_chk("held counter1", OFS_COUNT0 + 8'h04, x);
        check("held pins", {28'h0, pins}, {28'h0, pwm_pin});

        // Static levels while counting output is off
        wr(OFS_OUT_EN, 32'h00000000);
        wr(OFS_LEVEL, 32'h00000009);
        @(negedge hclk);
        check("static pins", 32'h9, {28'h0, pwm_pin});
        @(posedge hclk);
        rd_chk("level", OFS_LEVEL, 32'h00000009);

        // Unmapped place is ignored and reads zero
        wr(8'h40, 32'h00001234);
        rd_chk("unmapped", 8'h40, 32'h00000000);
        rd_chk("reload0 kept", OFS_RELOAD0, 32'h00000001);

        // Second reset in mid-run
        hresetn <= 1'b0;
        @(negedge hclk);
        check("pins in reset", 32'h0, {28'h0, pwm_pin});
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("reload1", OFS_RELOAD0 + 8'h04, 32'h0000FFFF);
        rd_chk("enable", OFS_ENABLE, 32'h00000000);
        test_done();
    end
endmodule // tb_top
